// file: etr_recorder.sv
// Bus-cycle trace recorder with AXI4-Lite register access
`default_nettype none
module etr_recorder import etr_pkg::*; (
	input wire logic aclk, // Emulator clock
	input wire logic aresetn, // Sync reset, active low
	input wire logic ce, // Clock enable, freezes all state
	input wire etr_cycle_t cyc, // Bus cycle of the core
	input wire logic cpu_running, // Run, continue or step active
	input wire logic cpu_low_power, // Core in halt or wait
	input wire etr_seq_t bus_event_sequencer, // Sequencer state
	input wire logic trigger_input_line, // External pin
	input wire logic [ETR_AIW-1:0] analyzer_input_line, // Pins
	input wire logic [ETR_BUS_AW-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [ETR_BUS_DW-1:0] s_axi_wdata, // Write data
	input wire logic [ETR_LANES-1:0] s_axi_wstrb, // Byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ETR_BUS_AW-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [ETR_BUS_DW-1:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready // Read data ready
);
	// Byte-lane merge of a register write
	function automatic logic [ETR_BUS_DW-1:0] merge_lanes(
		input logic [ETR_BUS_DW-1:0] old_v,
		input logic [ETR_BUS_DW-1:0] new_v,
		input logic [ETR_LANES-1:0] strb);
		merge_lanes = old_v;
		for (int b = 0; b < ETR_LANES; b++) begin
			if (strb[b]) begin
				merge_lanes[b*ETR_LANEW +: ETR_LANEW] =
					new_v[b*ETR_LANEW +: ETR_LANEW];
			end
		end
	endfunction : merge_lanes

	// Pin synchronisers
	logic [1:0] trig_sync; // Trigger pin, two stages
	logic [ETR_AIW-1:0] ai_s1; // Analyzer first stage
	logic [ETR_AIW-1:0] ai_s2; // Analyzer second stage
	// Timestamp
	logic [ETR_TSW-1:0] ts; // Current time in ns
	logic ts_wrap; // Counter just restarted
	// Software registers
	logic [ETR_CTRLW-1:0] ctrl; // Enable, qualify, gate
	logic [ETR_PW-1:0] index; // Record to read, 1 is oldest
	// Trace store
	etr_rec_t mem [ETR_DEPTH]; // Record storage
	logic [ETR_PW-1:0] wptr; // Next slot to write
	logic wrapped; // Store has filled at least once
	etr_cap_t cap_state; // Capture state
	etr_cap_t next_cap; // Next capture state
	logic gap_pend; // Gap seen, not yet flagged
	logic ts_disc_pend; // Restart lost in low power
	// AXI state
	logic [ETR_BUS_AW-1:0] aw_addr; // Latched write address
	logic [ETR_BUS_DW-1:0] w_data; // Latched write data
	logic [ETR_LANES-1:0] w_strb; // Latched strobes
	logic [ETR_BUS_DW-1:0] rd_word; // Selected read word
	logic rd_known; // Read address mapped

	// Timestamp source
	etr_tstamp etr_tstamp_i (
		.aclk (aclk),
		.aresetn (aresetn),
		.ce (ce),
		.stamp (ts),
		.wrap (ts_wrap)
	);

	// Capture qualification
	wire armed = ctrl[CTRL_EN] & cpu_running;
	wire gate = ctrl[CTRL_GATE] & bus_event_sequencer.trace_on;
	wire qual_ok = ~ctrl[CTRL_QUAL] | bus_event_sequencer.qualify;
	wire wr_bus = armed & gate & cyc.valid & qual_ok;
	wire force_ts = armed & ts_wrap & ~cpu_low_power;
	wire lost_ts = armed & ts_wrap & cpu_low_power;
	wire wr = wr_bus | force_ts;
	wire in_gap = (cap_state == CAP_GAP);

	// Write side decode
	wire do_wr = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	wire [ETR_BUS_DW-1:0] ctrl_merged =
		merge_lanes(ETR_BUS_DW'(ctrl), w_data, w_strb);
	wire [ETR_BUS_DW-1:0] index_merged =
		merge_lanes(ETR_BUS_DW'(index), w_data, w_strb);
	wire wr_ctrl = do_wr & (aw_addr == ETR_OFS_CTRL);
	wire wr_index = do_wr & (aw_addr == ETR_OFS_INDEX);
	wire clr = wr_ctrl & ctrl_merged[CTRL_CLR];
	wire wr_known = (aw_addr == ETR_OFS_CTRL) | (aw_addr == ETR_OFS_STATUS)
		| (aw_addr == ETR_OFS_WPTR) | (aw_addr == ETR_OFS_COUNT)
		| (aw_addr == ETR_OFS_INDEX) | (aw_addr == ETR_OFS_REC0)
		| (aw_addr == ETR_OFS_REC1) | (aw_addr == ETR_OFS_REC2);

	// Record assembly
	etr_rec_t next_rec; // Record written this cycle
	assign next_rec.addr = wr_bus ? cyc.addr : '0;
	assign next_rec.data = wr_bus ? cyc.data : '0;
	assign next_rec.region = wr_bus ? cyc.region : RGN_EMULATION_BOARD;
	assign next_rec.event_code = wr_bus ? cyc.event_code : EV_EXTRA_TS;
	assign next_rec.stamp = ts;
	assign next_rec.restart = force_ts;
	assign next_rec.ts_disc = ts_disc_pend;
	assign next_rec.trace_disc = wr_bus & (gap_pend | in_gap);
	assign next_rec.trigger = trig_sync[1];
	assign next_rec.analyzer = ai_s2;
	assign next_rec.level = bus_event_sequencer.level;
	assign next_rec.cond = bus_event_sequencer.cond;

	// Read side: map 1-based index onto the ring
	wire [ETR_PW-1:0] count = wrapped ? ETR_PW'(ETR_DEPTH) : wptr;
	wire [ETR_PW-1:0] idx_m1 = index - ETR_IDX_FIRST;
	wire [ETR_PW:0] ring_sum = {1'b0, wptr} + {1'b0, idx_m1};
	wire ring_over = ring_sum >= (ETR_PW+1)'(ETR_DEPTH);
	wire [ETR_PW:0] ring_fold = ring_sum - (ETR_PW+1)'(ETR_DEPTH);
	wire [ETR_PW-1:0] phys = !wrapped ? idx_m1 :
		(ring_over ? ring_fold[ETR_PW-1:0] : ring_sum[ETR_PW-1:0]);
	wire idx_ok = (index != '0) && (index <= count);
	wire etr_rec_t rd_rec = idx_ok ? mem[phys] : '0;
	wire [ETR_BUS_DW-1:0] status_word = ETR_BUS_DW'({ts_disc_pend,
		gap_pend, wrapped, cap_state == CAP_RUN});

	// Read word select
	always_comb begin
		rd_known = 1'b1;
		case (s_axi_araddr)
			ETR_OFS_CTRL: rd_word = ETR_BUS_DW'(ctrl);
			ETR_OFS_STATUS: rd_word = status_word;
			ETR_OFS_WPTR: rd_word = ETR_BUS_DW'(wptr);
			ETR_OFS_COUNT: rd_word = ETR_BUS_DW'(count);
			ETR_OFS_INDEX: rd_word = ETR_BUS_DW'(index);
			ETR_OFS_REC0: rd_word = rd_rec[0 +: ETR_BUS_DW];
			ETR_OFS_REC1: rd_word = rd_rec[ETR_BUS_DW +: ETR_BUS_DW];
			ETR_OFS_REC2: rd_word =
				ETR_BUS_DW'(rd_rec[ETR_RECW-1:2*ETR_BUS_DW]);
			default: begin
				rd_word = '0;
				rd_known = 1'b0;
			end
		endcase
	end

	// Capture state transitions
	always_comb begin
		case (cap_state)
			CAP_IDLE: next_cap = armed ? CAP_RUN : CAP_IDLE;
			CAP_RUN: next_cap = !armed ? CAP_IDLE :
				(gate ? CAP_RUN : CAP_GAP);
			CAP_GAP: next_cap = !armed ? CAP_IDLE :
				(gate ? CAP_RUN : CAP_GAP);
			default: next_cap = CAP_IDLE;
		endcase
	end

	// Pin synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_sync <= '0;
			ai_s1 <= '0;
			ai_s2 <= '0;
		end else if (ce) begin
			trig_sync <= {trig_sync[0], trigger_input_line};
			ai_s1 <= analyzer_input_line;
			ai_s2 <= ai_s1;
		end
	end

	// Software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= ETR_CTRL_RST;
			index <= ETR_IDX_FIRST;
		end else if (ce) begin
			if (wr_ctrl) ctrl <= ctrl_merged[ETR_CTRLW-1:0];
			if (wr_index) index <= index_merged[ETR_PW-1:0];
		end
	end

	// Ring pointer, wrap flag and pending marks
	always_ff @(posedge aclk) begin
		if (!aresetn || (ce && clr)) begin
			wptr <= '0;
			wrapped <= 1'b0;
			gap_pend <= 1'b0;
			ts_disc_pend <= 1'b0;
			cap_state <= CAP_IDLE;
		end else if (ce) begin
			cap_state <= next_cap;
			if (wr) begin
				wptr <= (wptr == ETR_LAST) ? '0 : wptr + 1'b1;
				if (wptr == ETR_LAST) wrapped <= 1'b1;
			end
			// Gap mark held until a bus record carries it
			gap_pend <= wr_bus ? 1'b0 : (gap_pend | in_gap);
			// Lost restart wins over the clear
			if (lost_ts) ts_disc_pend <= 1'b1;
			else if (wr) ts_disc_pend <= 1'b0;
		end
	end

	// Record storage, oldest slot overwritten
	always_ff @(posedge aclk) begin
		if (ce && wr && aresetn && !clr) mem[wptr] <= next_rec;
	end

	// AXI4-Lite write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ETR_RESP_OK;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			// Both halves held: commit and answer
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? ETR_RESP_OK : ETR_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= ETR_RESP_OK;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_known ? ETR_RESP_OK : ETR_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Steps used by the checks below, each by one check
	sequence s_store;
		ce && wr && !clr;
	endsequence
	sequence s_wrap_awake;
		ce && force_ts && !clr;
	endsequence
	sequence s_gap_then_write;
		(ce && in_gap && !clr) ##1 (ce && wr_bus && !clr);
	endsequence

	property p_wptr_roll;
		s_store and (wptr == ETR_LAST) |=> wptr == '0 && wrapped;
	endproperty
	a_wptr_roll: assert property (p_wptr_roll)
		else $error("pointer did not roll over");

	property p_halt_no_write;
		ce && !cpu_running && !clr |=> $stable(wptr);
	endproperty
	a_halt_no_write: assert property (p_halt_no_write)
		else $error("record stored while halted");

	property p_oldest_first;
		wrapped && index == ETR_IDX_FIRST |-> phys == wptr;
	endproperty
	a_oldest_first: assert property (p_oldest_first)
		else $error("index one is not the oldest");

	property p_rec_bus;
		ce && wr_bus && !clr |=> mem[$past(wptr)].addr == $past(cyc.addr)
			&& mem[$past(wptr)].data == $past(cyc.data)
			&& mem[$past(wptr)].region == $past(cyc.region)
			&& mem[$past(wptr)].event_code == $past(cyc.event_code);
	endproperty
	a_rec_bus: assert property (p_rec_bus)
		else $error("bus fields not stored");

	property p_restart;
		s_wrap_awake |=> mem[$past(wptr)].restart
			&& mem[$past(wptr)].stamp == $past(ts)
			&& wptr != $past(wptr);
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart record missing");

	property p_lost_restart;
		ce && lost_ts && !clr |=> ts_disc_pend;
	endproperty
	a_lost_restart: assert property (p_lost_restart)
		else $error("lost restart not marked");

	property p_gap_flag;
		s_gap_then_write |=> mem[$past(wptr)].trace_disc;
	endproperty
	a_gap_flag: assert property (p_gap_flag)
		else $error("gap not flagged");

	property p_pins_seq;
		ce && wr_bus && !clr |=> mem[$past(wptr)].trigger
			== $past(trig_sync[1]) && mem[$past(wptr)].level
			== $past(bus_event_sequencer.level)
			&& mem[$past(wptr)].cond == $past(bus_event_sequencer.cond);
	endproperty
	a_pins_seq: assert property (p_pins_seq)
		else $error("pin or sequencer state not stored");

	property p_qualify;
		ce && armed && gate && cyc.valid && ctrl[CTRL_QUAL]
			&& !bus_event_sequencer.qualify && !ts_wrap && !clr
			|=> $stable(wptr);
	endproperty
	a_qualify: assert property (p_qualify)
		else $error("unqualified cycle stored");
endmodule : etr_recorder
`default_nettype wire

// file: etr_pkg.sv
// Shared constants and types of the bus-cycle trace recorder
`default_nettype none
package etr_pkg;
	// Trace store geometry
	localparam int ETR_DEPTH = 256000; // Records retained
	localparam int ETR_PW = 18; // Pointer and index width
	localparam logic [ETR_PW-1:0] ETR_LAST = ETR_PW'(ETR_DEPTH - 1);
	localparam logic [ETR_PW-1:0] ETR_IDX_FIRST = 18'h00001; // Oldest
	// Field widths
	localparam int ETR_AW = 24; // Address bus
	localparam int ETR_DW = 8; // Data bus
	localparam int ETR_AIW = 8; // Analyzer input lines
	localparam int ETR_TSW = 30; // Timestamp counter
	localparam int ETR_CNDW = 6; // e1 e2 if e3 e4 else
	localparam int ETR_LVLW = 2; // Sequencer level 1..4 as 0..3
	// Timing: one clock period per timestamp tick
	localparam int ETR_CLK_PERIOD_NS = 8; // 125 MHz
	localparam logic [ETR_TSW-1:0] ETR_TS_STEP = ETR_TSW'(ETR_CLK_PERIOD_NS);
	localparam logic [ETR_TSW-1:0] ETR_TS_LAST = ETR_TSW'(0) - ETR_TS_STEP;
	// Memory region codes
	typedef enum logic [1:0] {
		RGN_EMULATION_BOARD = 2'h0, // emulation_board_memory
		RGN_TARGET_BOARD = 2'h1,
		RGN_INTERNAL_CHIP = 2'h2,
		RGN_USER_BOARD = 2'h3
	} etr_region_t;
	// Event type codes
	typedef enum logic [2:0] {
		EV_STACK_RD = 3'h0,
		EV_STACK_WR = 3'h1,
		EV_DIRECT_RD = 3'h2,
		EV_DIRECT_WR = 3'h3,
		EV_DISCARDED = 3'h4,
		EV_EXTRA_TS = 3'h5,
		EV_OTHER = 3'h6
	} etr_event_t;
	// One bus cycle offered by the core
	typedef struct packed {
		logic valid;
		etr_event_t event_code;
		etr_region_t region;
		logic [ETR_DW-1:0] data;
		logic [ETR_AW-1:0] addr;
	} etr_cycle_t;
	// Sequencer state per cycle
	typedef struct packed {
		logic trace_on; // Capture gate
		logic qualify; // Cycle meets programmed conditions
		logic [ETR_LVLW-1:0] level;
		logic [ETR_CNDW-1:0] cond;
	} etr_seq_t;
	// One trace record; word 0 = addr/data, 1 = stamp/region, 2 = rest
	typedef struct packed {
		logic [ETR_CNDW-1:0] cond;
		logic [ETR_LVLW-1:0] level;
		logic [ETR_AIW-1:0] analyzer;
		logic trigger;
		logic trace_disc;
		logic ts_disc;
		logic restart;
		etr_event_t event_code;
		etr_region_t region;
		logic [ETR_TSW-1:0] stamp;
		logic [ETR_DW-1:0] data;
		logic [ETR_AW-1:0] addr;
	} etr_rec_t;
	localparam int ETR_RECW = $bits(etr_rec_t);
	// Capture state, one-hot
	typedef enum logic [2:0] {
		CAP_IDLE = 3'h1,
		CAP_RUN = 3'h2,
		CAP_GAP = 3'h4
	} etr_cap_t;
	// Register bus
	localparam int ETR_BUS_AW = 8;
	localparam int ETR_BUS_DW = 32;
	localparam int ETR_LANES = 4;
	localparam int ETR_LANEW = 8;
	localparam logic [7:0] ETR_OFS_CTRL = 8'h00;
	localparam logic [7:0] ETR_OFS_STATUS = 8'h04;
	localparam logic [7:0] ETR_OFS_WPTR = 8'h08;
	localparam logic [7:0] ETR_OFS_COUNT = 8'h0c;
	localparam logic [7:0] ETR_OFS_INDEX = 8'h10;
	localparam logic [7:0] ETR_OFS_REC0 = 8'h14;
	localparam logic [7:0] ETR_OFS_REC1 = 8'h18;
	localparam logic [7:0] ETR_OFS_REC2 = 8'h1c;
	// Control bits
	localparam int ETR_CTRLW = 3;
	localparam int CTRL_EN = 0; // Tracing enabled
	localparam int CTRL_QUAL = 1; // Sequencer qualifies cycles
	localparam int CTRL_GATE = 2; // Viewer capture gate
	localparam int CTRL_CLR = 3; // Write one: clear store
	localparam logic [ETR_CTRLW-1:0] ETR_CTRL_RST = 3'h4;
	localparam logic [1:0] ETR_RESP_OK = 2'h0;
	localparam logic [1:0] ETR_RESP_SLVERR = 2'h2;
endpackage : etr_pkg
`default_nettype wire

// file: etr_tstamp.sv
// Free-running nanosecond timestamp counter with restart pulse
`default_nettype none
module etr_tstamp import etr_pkg::*; (
	input wire logic aclk, // Emulator clock
	input wire logic aresetn, // Sync reset, active low
	input wire logic ce, // Clock enable
	output logic [ETR_TSW-1:0] stamp, // Time in ns
	output logic wrap // High in the cycle after a restart
);
	logic [ETR_TSW:0] next_sum; // Carry marks the restart

	assign next_sum = {1'b0, stamp} + {1'b0, ETR_TS_STEP};

	// Counter and restart flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stamp <= '0;
			wrap <= 1'b0;
		end else if (ce) begin
			stamp <= next_sum[ETR_TSW-1:0];
			wrap <= next_sum[ETR_TSW];
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Each tick adds one clock period in ns
	property p_ts_step;
		ce |=> stamp == ETR_TSW'($past(stamp) + ETR_TS_STEP);
	endproperty
	a_ts_step: assert property (p_ts_step)
		else $error("timestamp step wrong");

	// Counter restarts at zero and flags it
	property p_ts_wrap;
		ce && stamp == ETR_TS_LAST |=> wrap && stamp == '0;
	endproperty
	a_ts_wrap: assert property (p_ts_wrap)
		else $error("timestamp restart not flagged");
endmodule : etr_tstamp
`default_nettype wire

// file: etr_core_model.sv
// Model of the emulated core bus and breakpoint sequencer
`default_nettype none
module etr_core_model import etr_pkg::*; (
	input wire logic aclk, // Emulator clock
	output etr_cycle_t cyc, // Bus cycle
	output logic cpu_running, // Core executing
	output logic cpu_low_power, // Core in halt or wait
	output etr_seq_t seq, // Sequencer state
	output logic trig, // Trigger pin
	output logic [ETR_AIW-1:0] ai // Analyzer pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle levels at start
	initial begin
		cyc = '0;
		cpu_running = 1'b0;
		cpu_low_power = 1'b0;
		seq = 10'h200;
		trig = 1'b0;
		ai = '0;
	end
	// Bus cycle offered for step k
	function automatic etr_cycle_t cyc_of(input int k);
		etr_cycle_t c;
		c.valid = 1'b1;
		c.event_code = etr_event_t'(k % 7);
		c.region = etr_region_t'(k % 4);
		c.data = 8'hc0 ^ 8'(k);
		c.addr = 24'h012300 + ETR_AW'(k);
		return c;
	endfunction : cyc_of
	// Core run state and pin levels
	task set_core(input logic r, input logic t, input logic [7:0] a);
		@(posedge aclk);
		cpu_running <= r;
		trig <= t;
		ai <= a;
		// Pins pass two flip-flops before a record may sample them
		repeat (2) @(posedge aclk);
	endtask : set_core
	// Back-to-back cycles; masks give gate and qualify per cycle
	task burst(input int k0, input int n, input logic [7:0] on_m,
		input logic [7:0] q_m);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			cyc <= cyc_of(k0 + i);
			seq <= {on_m[i], q_m[i], ETR_LVLW'((k0 + i) % 4),
				ETR_CNDW'(1 << ((k0 + i) % 6))};
		end
		@(posedge aclk);
		cyc <= {1'b0, ~cyc[36:0]}; // Released lines show inverse
		seq <= 10'h200;
	endtask : burst
endmodule : etr_core_model
`default_nettype wire

// file: etr_recorder_tb.sv
// Self-checking bench of the bus-cycle trace recorder
`default_nettype none
module etr_recorder_tb import etr_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0; // Emulator clock
	logic aresetn = 1'b0; // Sync reset, active low
	logic ce = 1'b1; // Clock enable
	etr_cycle_t cyc; // Core bus cycle
	logic run; // Core executing
	logic low_pwr; // Core sleeping
	etr_seq_t seq; // Sequencer state
	logic trig; // Trigger pin
	logic [ETR_AIW-1:0] ai; // Analyzer pins
	logic [7:0] awaddr = '0, araddr = '0; // Bus addresses
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0; // Write handshakes
	logic arvalid = 1'b0, rready = 1'b0; // Read handshakes
	logic [31:0] wdata = '0, rdata; // Bus data
	logic awready, wready, bvalid, arready, rvalid; // Slave handshakes
	logic [1:0] bresp, rresp; // Responses
	int miscompares = 0, cmp_count = 0; // Tallies
	logic [31:0] w0, w1, w2, rv; // Read results
	logic [1:0] rs; // Last response
	logic [29:0] prev_ts; // Previous record stamp
	// Free-running clock
	always #4 aclk = ~aclk;
	etr_core_model etr_core_model_i (.aclk(aclk), .cyc(cyc),
		.cpu_running(run), .cpu_low_power(low_pwr), .seq(seq),
		.trig(trig), .ai(ai));
	etr_recorder etr_recorder_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.cyc(cyc), .cpu_running(run), .cpu_low_power(low_pwr),
		.bus_event_sequencer(seq), .trigger_input_line(trig),
		.analyzer_input_line(ai), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	// Verdict and end of run
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	// One comparison
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk
	// Wait ran out
	task hang(input string nm);
		$display("mismatch %s expected answer seen none", nm);
		miscompares++;
		report_and_stop();
	endtask : hang
	// Write: address and data offered together, held until taken
	task wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 30 && bvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end
		if (bvalid !== 1'b1) hang("write response");
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	// Read: address held until taken, data taken at rvalid edge
	task rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 30 && rvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		if (rvalid !== 1'b1) hang("read data");
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	// Read a register and compare value and response
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		rd(a, rv, rs);
		chk(nm, e, rv);
		chk(nm, 32'(er), 32'(rs));
	endtask : rchk
	// Expected third record word
	function automatic logic [31:0] exp_w2(int k, logic td, logic t,
		logic [7:0] a);
		return {9'h0, ETR_CNDW'(1 << (k % 6)), ETR_LVLW'(k % 4), a, t, td,
			2'b00, 3'(k % 7)};
	endfunction : exp_w2
	// Fetch record i and compare with model step k
	task chkrec(int i, int k, logic td, logic t, logic [7:0] a);
		etr_cycle_t c;
		c = etr_core_model_i.cyc_of(k);
		wr(ETR_OFS_INDEX, 32'(i), rs);
		rd(ETR_OFS_REC0, w0, rs);
		rd(ETR_OFS_REC1, w1, rs);
		rd(ETR_OFS_REC2, w2, rs);
		chk("rec addr data", {c.data, c.addr}, w0);
		chk("rec region", 32'(c.region), 32'(w1[31:30]));
		chk("rec flags", exp_w2(k, td, t, a), w2);
	endtask : chkrec
	// Main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values and map
		rchk("ctrl", ETR_OFS_CTRL, 32'h4, ETR_RESP_OK);
		rchk("status", ETR_OFS_STATUS, 32'h0, ETR_RESP_OK);
		rchk("count", ETR_OFS_COUNT, 32'h0, ETR_RESP_OK);
		rchk("index", ETR_OFS_INDEX, 32'h1, ETR_RESP_OK);
		rchk("unmapped", 8'h20, 32'h0, ETR_RESP_SLVERR);
		wr(ETR_OFS_WPTR, 32'h55, rs);
		chk("ro write resp", 32'(ETR_RESP_OK), 32'(rs));
		rchk("wptr", ETR_OFS_WPTR, 32'h0, ETR_RESP_OK);
		wr(8'h24, 32'h1, rs);
		chk("unmapped write", 32'(ETR_RESP_SLVERR), 32'(rs));
		$display("test 1 done");
		// Capture needs enable and a running core
		etr_core_model_i.set_core(1'b0, 1'b1, 8'ha5);
		etr_core_model_i.burst(0, 2, 8'hff, 8'h00);
		rchk("count off", ETR_OFS_COUNT, 32'h0, ETR_RESP_OK);
		wr(ETR_OFS_CTRL, 32'h5, rs);
		etr_core_model_i.burst(0, 2, 8'hff, 8'h00);
		rchk("count halted", ETR_OFS_COUNT, 32'h0, ETR_RESP_OK);
		etr_core_model_i.set_core(1'b1, 1'b1, 8'ha5);
		rchk("ctrl on", ETR_OFS_CTRL, 32'h5, ETR_RESP_OK);
		etr_core_model_i.burst(0, 8, 8'hff, 8'h00);
		rchk("count run", ETR_OFS_COUNT, 32'h8, ETR_RESP_OK);
		rchk("wptr run", ETR_OFS_WPTR, 32'h8, ETR_RESP_OK);
		for (int i = 1; i <= 8; i++) begin
			chkrec(i, i - 1, 1'b0, 1'b1, 8'ha5);
			if (i > 1)
				chk("stamp step", 32'h8, 32'(w1[29:0] - prev_ts));
			prev_ts = w1[29:0];
		end
		etr_core_model_i.set_core(1'b0, 1'b1, 8'ha5);
		etr_core_model_i.burst(8, 2, 8'hff, 8'h00);
		rchk("count break", ETR_OFS_COUNT, 32'h8, ETR_RESP_OK);
		$display("test 2 done");
		// Clear, then sequencer qualify and gap
		wr(ETR_OFS_CTRL, 32'hf, rs);
		rchk("ctrl clr", ETR_OFS_CTRL, 32'h7, ETR_RESP_OK);
		rchk("count clr", ETR_OFS_COUNT, 32'h0, ETR_RESP_OK);
		etr_core_model_i.set_core(1'b1, 1'b0, 8'h3c);
		etr_core_model_i.burst(20, 4, 8'hff, 8'h05);
		etr_core_model_i.burst(24, 2, 8'h00, 8'hff);
		etr_core_model_i.burst(26, 2, 8'hff, 8'hff);
		rchk("count qual", ETR_OFS_COUNT, 32'h4, ETR_RESP_OK);
		chkrec(1, 20, 1'b0, 1'b0, 8'h3c);
		chkrec(2, 22, 1'b0, 1'b0, 8'h3c);
		chkrec(3, 26, 1'b1, 1'b0, 8'h3c);
		chkrec(4, 27, 1'b0, 1'b0, 8'h3c);
		$display("test 3 done");
		// Viewer gate off and on again
		wr(ETR_OFS_CTRL, 32'h3, rs);
		etr_core_model_i.burst(30, 1, 8'hff, 8'hff);
		wr(ETR_OFS_CTRL, 32'h7, rs);
		etr_core_model_i.burst(31, 1, 8'hff, 8'hff);
		rchk("count gate", ETR_OFS_COUNT, 32'h5, ETR_RESP_OK);
		chkrec(5, 31, 1'b1, 1'b0, 8'h3c);
		$display("test 4 done");
		report_and_stop();
	end
endmodule : etr_recorder_tb
`default_nettype wire
